// [shared/thermal_alarm_cfg.svh]
// Constants of the thermal alarm block: register offsets, field positions,
// reset values, hysteresis steps and bus address prefixes.
// Assumes inclusion by bare name from the package and the design file.
`ifndef THERMAL_ALARM_CFG_SVH
`define THERMAL_ALARM_CFG_SVH

`define OFF_SETUP        8'h00
`define OFF_UPPER        8'h04
`define OFF_LOWER        8'h08
`define OFF_CRIT         8'h0c
`define OFF_TEMP         8'h10
`define OFF_BUSOPT       8'h14
`define OFF_LINK         8'h18

`define SETUP_MODE_INT   0
`define SETUP_POL_HIGH   1
`define SETUP_CRIT_ONLY  2
`define SETUP_OUT_EN     3
`define SETUP_STATUS     4
`define SETUP_CLEAR      5
`define SETUP_WIN_LOCK   6
`define SETUP_CRIT_LOCK  7
`define SETUP_SHUTDOWN   8
`define SETUP_HYS_LO     9
`define SETUP_HYS_HI     10
`define BUSOPT_FREEZE    4

`define SETUP_RESET      16'h0000
`define BUSOPT_RESET     16'h0021
`define TRIP_RESET       13'h0000

`define TEMP_MSB         12
`define FLAG_CRIT        15
`define FLAG_ABOVE       14
`define FLAG_BELOW       13

// Hysteresis in temperature counts of 0.0625 degrees.
`define HYS_OFF          13'h0000
`define HYS_1P5          13'h0018
`define HYS_3P0          13'h0030
`define HYS_6P0          13'h0060

`define PREFIX_SENSOR    4'h3
`define PREFIX_EEPROM    4'ha
`define PREFIX_PROTECT   4'h6
`define ADDR_BITS        4'h8

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [shared/thermal_alarm_pkg.sv]
// Types of the thermal alarm block.
// Assumes the constants header is on the include path.
`include "thermal_alarm_cfg.svh"
package thermal_alarm_pkg;

  typedef enum logic [1:0] {LS_IDLE, LS_ADDR, LS_ACK, LS_HOLD} link_state_t;

  typedef struct packed {
    logic [2:0]  pins_s1;
    logic [2:0]  pins_s2;
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_q;
    logic        sda_q;
    link_state_t link;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [2:0]  addr_low;
    logic [6:0]  last_addr;
    logic [2:0]  hits;
    logic        sda_drive;
    logic [15:0] setup;
    logic [15:0] busopt;
    logic [12:0] upper;
    logic [12:0] lower;
    logic [12:0] crit;
    logic [12:0] temp;
    logic        above;
    logic        below;
    logic        crit_hit;
    logic        int_latch;
    logic        evt;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage : thermal_alarm_pkg

// [src/thermal_alarm_event_logic.sv]
// Thermal alarm output logic with window and critical trips, setup word,
// temperature flags and two-wire slave address recognition.
// Assumes one 100 MHz clock, AXI4-Lite register access, a converter that
// strobes results in this clock domain, and pins sampled from outside.
//
// Summary of operation
// (R1) Slave address is a fixed 4-bit prefix plus three pin bits.
// (R2) Address pins are sampled at every bus start condition.
// (R3) Sensor answers only to its own prefix with the sampled pin bits.
// (R4) EEPROM data and protection prefixes are recognised with the pin bits.
// (R5) Undriven address pins read as zero through internal pull-downs.
// (R6) Bus bytes move most significant bit first on master clock edges.
// (R7) Alarm pin is open-drain: it only pulls low or releases.
// (R8) Setup bit 0 picks interrupt or comparator behaviour.
// (R9) Setup bit 2 picks all three bands or the critical band only.
// (R10) Setup bits 10 to 9 select the hysteresis subtracted from trips.
// (R11) Setup bit 6 locks window trips, bit 7 locks the critical trip.
// (R12) Alarm pin stays released after reset until setup bit 3 is set.
// (R13) Band and mode bits may change while the output stays enabled.
// (R14) Setup bit 1 selects active high or active low alarm.
// (R15) Setup bit 4 reads alarm status; bit 5 clears a latched alarm.
// (R16) Shutdown releases the alarm unless bus option bit 4 freezes it.
// (R17) Temperature word flags: critical, above window, below window.
// (R18) Comparator asserts outside the window, releases inside by hysteresis; code sets below under lower less hysteresis, clears at lower.
// (R19) Critical-only asserts at critical trip, releases below it less hysteresis.
// (R20) Interrupt mode latches each window crossing until software clears it.
// (R21) Inside the critical band behaviour is comparator, mode bit ignored.
// (R22) The master keeps the bus clock within its allowed rates.
// (R23) Writing one to clear releases an interrupt alarm until next trigger.
// (R24) A critical alarm is not cleared by software, only by cooling.
// (R25) Hysteresis choices are off, 1.5, 3 and 6 degrees.
// (R26) After reset the alarm is in comparator mode with status cleared.
// (R27) Comparisons and flags update when a new conversion result lands.
`timescale 1ns/10ps
`default_nettype none
`include "thermal_alarm_cfg.svh"

module thermal_alarm_event_logic (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Conversion results, same clock domain.
  input  wire logic [12:0] temp_value_i,
  input  wire logic        temp_valid_i,
  // Address-select pins.
  input  wire logic        addr_sel_bit_zero_i,
  input  wire logic        addr_sel_bit_one_i,
  input  wire logic        addr_sel_bit_two_i,
  // Two-wire bus.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // Thermal alarm pin.
  output logic             alarm_o,
  output logic             alarm_oe_n_o,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  thermal_alarm_pkg::state_t st;
  thermal_alarm_pkg::state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [12:0] hys_count(input logic [1:0] sel);
    case (sel)
      2'h1:    hys_count = `HYS_1P5;
      2'h2:    hys_count = `HYS_3P0;
      2'h3:    hys_count = `HYS_6P0;
      default: hys_count = `HYS_OFF;
    endcase
  endfunction : hys_count

  // Merges a write word into a 16-bit register under byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  function automatic logic lt(input logic [12:0] a, input logic [12:0] b);
    lt = $signed(a) < $signed(b);
  endfunction : lt

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic [12:0] hys;
  logic [12:0] t;
  logic        outside_old;
  logic        outside_new;
  logic        alarm_now;
  logic        do_write;
  logic        clear_req;
  logic [15:0] wval;
  logic [15:0] temp_word;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [3:0]  prefix;

  always_comb begin
    next_st     = st;
    hys         = hys_count(st.setup[`SETUP_HYS_HI:`SETUP_HYS_LO]); // [R10] [R25]
    t           = temp_value_i;
    outside_old = st.above | st.below;
    outside_new = outside_old;
    alarm_now   = 1'b0;
    clear_req   = 1'b0;
    wval        = 16'h0000;
    prefix      = 4'h0;
    temp_word   = {st.crit_hit, st.above, st.below, st.temp};       // [R17]

    // Pin and bus synchronisers; only the second stages and the delayed bus copies feed logic.
    next_st.pins_s1 = {addr_sel_bit_two_i, addr_sel_bit_one_i,
                       addr_sel_bit_zero_i};                        // [R5]
    next_st.pins_s2 = st.pins_s1;
    next_st.scl_s   = {st.scl_s[0], scl_i};
    next_st.sda_s   = {st.sda_s[0], sda_i};
    next_st.scl_q   = st.scl_s[1];
    next_st.sda_q   = st.sda_s[1];
    scl_rise   = st.scl_s[1] & ~st.scl_q;
    scl_fall   = ~st.scl_s[1] & st.scl_q;
    start_cond = st.scl_s[1] & st.scl_q & ~st.sda_s[1] & st.sda_q;
    stop_cond  = st.scl_s[1] & st.scl_q & st.sda_s[1] & ~st.sda_q;

    // Two-wire address phase.
    case (st.link)
      thermal_alarm_pkg::LS_IDLE: begin
      end
      thermal_alarm_pkg::LS_ADDR: begin
        if (scl_rise) begin
          next_st.shift   = {st.shift[6:0], st.sda_s[1]};           // [R6]
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end else if (scl_fall && st.bit_cnt == `ADDR_BITS) begin
          prefix            = st.shift[7:4];
          next_st.last_addr = st.shift[7:1];
          next_st.hits = {prefix == `PREFIX_PROTECT && st.shift[3:1] == st.addr_low,
                          prefix == `PREFIX_EEPROM && st.shift[3:1] == st.addr_low,
                          prefix == `PREFIX_SENSOR && st.shift[3:1] == st.addr_low}; // [R1] [R4]
          if (prefix == `PREFIX_SENSOR && st.shift[3:1] == st.addr_low) begin // [R3]
            next_st.sda_drive = 1'b1;
            next_st.link      = thermal_alarm_pkg::LS_ACK;
          end else begin
            next_st.link = thermal_alarm_pkg::LS_HOLD;
          end
        end
      end
      thermal_alarm_pkg::LS_ACK: begin
        if (scl_fall) begin
          next_st.sda_drive = 1'b0;
          next_st.link      = thermal_alarm_pkg::LS_HOLD;
        end
      end
      thermal_alarm_pkg::LS_HOLD: begin
      end
      default: next_st.link = thermal_alarm_pkg::LS_IDLE;
    endcase
    if (start_cond) begin
      next_st.addr_low  = st.pins_s2;                               // [R2]
      next_st.bit_cnt   = 4'h0;
      next_st.sda_drive = 1'b0;
      next_st.link      = thermal_alarm_pkg::LS_ADDR;
    end else if (stop_cond) begin
      next_st.sda_drive = 1'b0;
      next_st.link      = thermal_alarm_pkg::LS_IDLE;
    end

    // AXI4-Lite write channel: address and data taken in either order.
    if (s_axi_awvalid_i && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.w_strb = s_axi_wstrb_i;
    end
    do_write = st.aw_held & st.w_held;
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `RESP_OKAY;
      case (st.aw_addr)
        `OFF_SETUP: begin
          wval = merge16(st.setup, st.w_data, st.w_strb);
          clear_req = wval[`SETUP_CLEAR];                           // [R15]
          wval[`SETUP_CLEAR]  = 1'b0;
          wval[`SETUP_STATUS] = 1'b0;
          next_st.setup = wval;                                     // [R13]
          // Entering interrupt mode drops a comparator alarm.
          if (wval[`SETUP_MODE_INT] && !st.setup[`SETUP_MODE_INT]) begin
            next_st.int_latch = 1'b0;
          end
        end
        `OFF_UPPER: begin
          wval = merge16({3'h0, st.upper}, st.w_data, st.w_strb);
          if (!st.setup[`SETUP_WIN_LOCK]) begin                     // [R11]
            next_st.upper = wval[`TEMP_MSB:0];
          end
        end
        `OFF_LOWER: begin
          wval = merge16({3'h0, st.lower}, st.w_data, st.w_strb);
          if (!st.setup[`SETUP_WIN_LOCK]) begin                     // [R11]
            next_st.lower = wval[`TEMP_MSB:0];
          end
        end
        `OFF_CRIT: begin
          wval = merge16({3'h0, st.crit}, st.w_data, st.w_strb);
          if (!st.setup[`SETUP_CRIT_LOCK]) begin                    // [R11]
            next_st.crit = wval[`TEMP_MSB:0];
          end
        end
        `OFF_BUSOPT: next_st.busopt = merge16(st.busopt, st.w_data, st.w_strb);
        `OFF_TEMP, `OFF_LINK: begin
        end
        default: next_st.bresp = `RESP_SLVERR;
      endcase
    end else if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end

    // Software clear of the interrupt latch; a crossing below still wins.
    if (clear_req) begin
      next_st.int_latch = 1'b0;                                     // [R23]
    end

    // Alarm evaluation on each new conversion result, paused in shutdown.
    if (temp_valid_i && !st.setup[`SETUP_SHUTDOWN]) begin           // [R27]
      next_st.temp = t;
      // Critical band: set at trip, held until below trip less hysteresis.
      if (!lt(t, st.crit)) begin
        next_st.crit_hit = 1'b1;
      end else if (lt(t, st.crit - hys)) begin
        next_st.crit_hit = 1'b0;                                    // [R24]
      end
      // Window: upper trip with hysteresis on the way back in, lower trip with hysteresis on the way out.
      if (lt(st.upper, t)) begin
        next_st.above = 1'b1;
      end else if (!lt(st.upper - hys, t)) begin
        next_st.above = 1'b0;                                       // [R18]
      end
      if (lt(t, st.lower - hys)) begin
        next_st.below = 1'b1;
      end else if (!lt(t, st.lower)) begin
        next_st.below = 1'b0;                                       // [R18]
      end
      outside_new = next_st.above | next_st.below;
      if (outside_new != outside_old) begin
        next_st.int_latch = 1'b1;                                   // [R20]
      end
    end

    // Output decision.
    if (st.setup[`SETUP_CRIT_ONLY]) begin
      alarm_now = st.crit_hit;                                      // [R9] [R19]
    end else if (st.crit_hit) begin
      alarm_now = 1'b1;                                             // [R21] [R24]
    end else if (st.setup[`SETUP_MODE_INT]) begin
      alarm_now = st.int_latch;                                     // [R8] [R20]
    end else begin
      alarm_now = st.above | st.below;                              // [R8] [R18]
    end
    if (st.setup[`SETUP_SHUTDOWN]) begin
      next_st.evt = st.busopt[`BUSOPT_FREEZE] & st.evt;             // [R16]
    end else begin
      next_st.evt = alarm_now;
    end

    // AXI4-Lite read channel.
    if (s_axi_arvalid_i && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      case (s_axi_araddr_i)
        `OFF_SETUP: begin
          next_st.rdata[15:0] = st.setup;
          next_st.rdata[`SETUP_STATUS] = st.evt;                    // [R15]
        end
        `OFF_UPPER:  next_st.rdata[12:0] = st.upper;
        `OFF_LOWER:  next_st.rdata[12:0] = st.lower;
        `OFF_CRIT:   next_st.rdata[12:0] = st.crit;
        `OFF_TEMP:   next_st.rdata[15:0] = temp_word;               // [R17]
        `OFF_BUSOPT: next_st.rdata[15:0] = st.busopt;
        `OFF_LINK:   next_st.rdata[12:0] = {st.hits, st.addr_low, st.last_addr};
        default:     next_st.rresp = `RESP_SLVERR;
      endcase
    end else if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st        <= '0;
      st.link   <= thermal_alarm_pkg::LS_IDLE;
      st.scl_s  <= 2'h3;
      st.sda_s  <= 2'h3;
      st.scl_q  <= 1'b1;
      st.sda_q  <= 1'b1;
      st.setup  <= `SETUP_RESET;                                    // [R26]
      st.busopt <= `BUSOPT_RESET;
      st.upper  <= `TRIP_RESET;
      st.lower  <= `TRIP_RESET;
      st.crit   <= `TRIP_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_comb begin
    sda_o      = 1'b0;
    sda_oe_n_o = ~st.sda_drive;
    alarm_o    = 1'b0;                                              // [R7]
    // Pulls low for an asserted active-low alarm or an idle active-high one.
    alarm_oe_n_o = ~(st.setup[`SETUP_OUT_EN] &
                     (st.evt ^ st.setup[`SETUP_POL_HIGH]));         // [R12] [R14]
  end

  assign s_axi_awready_o = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready_o  = ~st.w_held & ~st.bvalid;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_arready_o = ~st.rvalid;
  assign s_axi_rvalid_o  = st.rvalid;
  assign s_axi_rdata_o   = st.rdata;
  assign s_axi_rresp_o   = st.rresp;

endmodule : thermal_alarm_event_logic
`default_nettype wire

// [test/host_master_model.sv]
// Two-wire bus master that sends one address byte per frame.
// Assumes an external pull-up: the bench ands all pull-downs into sda_i.
`timescale 1ns/10ps
`default_nettype none
module host_master_model (
  output logic      scl_o,
  output logic      sda_rel_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'h1;
    sda_rel_o = 1'h1;
  end
  // Start, eight bits, acknowledge slot, stop; clock stands high between frames.
  task automatic frame(input logic [7:0] b, output logic ack);
    int i;
    // Offset from the device clock so that no bus pin moves as it is sampled.
    #2 sda_rel_o = 1'h0;
    #40 scl_o = 1'h0;
    for (i = 7; i >= 0; i--) begin
      #20 sda_rel_o = b[i];
      #20 scl_o = 1'h1;
      #40 scl_o = 1'h0;
    end
    #20 sda_rel_o = 1'h1;
    #20 scl_o = 1'h1;
    #20 ack = !sda_i;
    #20 scl_o = 1'h0;
    #20 sda_rel_o = 1'h0;
    #20 scl_o = 1'h1;
    #40 sda_rel_o = 1'h1;
    #40;
  endtask : frame
endmodule : host_master_model
`default_nettype wire

// [test/test_thermal_alarm_event_logic.sv]
// Testbench of the thermal alarm block: registers, alarm pin, bus address.
// Assumes the constants header on the include path and the host model.
`timescale 1ns/10ps
`default_nettype none
`include "thermal_alarm_cfg.svh"
`define CHK(n, g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, (e), (g)); end end
module test_thermal_alarm_event_logic;
  logic        clock_i = 1'h0;
  logic        resetn_i = 1'h0;
  logic [12:0] temp_value_i = 13'h0;
  logic        temp_valid_i = 1'h0;
  logic [2:0]  pins = 3'h0;
  logic        addr_sel_bit_zero_i, addr_sel_bit_one_i, addr_sel_bit_two_i;
  logic        scl_i, sda_i, sda_rel, sda_o, sda_oe_n_o, alarm_o, alarm_oe_n_o, ack;
  logic [7:0]  s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, seed = 32'h9fd7;
  logic [3:0]  s_axi_wstrb_i = 4'h3;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, xb, exp_b[$];
  logic [33:0] xr, exp_r[$];
  int          errors = 0, num_checks = 0, k;
  assign {addr_sel_bit_two_i, addr_sel_bit_one_i, addr_sel_bit_zero_i} = pins;
  assign sda_i = sda_rel & sda_oe_n_o;
  thermal_alarm_event_logic dut_u (.*);
  host_master_model host_u (.scl_o(scl_i), .sda_rel_o(sda_rel), .sda_i(sda_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic test_done;
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    int n;
    @(posedge clock_i);
    exp_b.push_back(r);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0, d};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_awready_o === 1'h1) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o === 1'h1) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o === 1'h1) break;
    end
    s_axi_bready_i <= 1'h0;
    if (n == 40) begin errors++; test_done(); end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    @(posedge clock_i);
    exp_r.push_back(e);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_arready_o === 1'h1) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o === 1'h1) break;
    end
    s_axi_rready_i <= 1'h0;
    if (n == 40) begin errors++; test_done(); end
  endtask : rd
  task automatic temp(input logic [12:0] t);
    @(posedge clock_i);
    temp_value_i <= t;
    temp_valid_i <= 1'h1;
    @(posedge clock_i);
    temp_valid_i <= 1'h0;
  endtask : temp
  task automatic pin(input logic e);
    repeat (4) @(posedge clock_i);
    `CHK("alarm pin", alarm_oe_n_o, e)
  endtask : pin
  // Takes the oldest noted answer whenever the bus hands one back.
  always @(posedge clock_i) begin
    if (s_axi_rvalid_o === 1'h1 && s_axi_rready_i && exp_r.size() > 0) begin
      xr = exp_r.pop_front();
      `CHK("read", {s_axi_rresp_o, s_axi_rdata_o}, xr)
    end
    if (s_axi_bvalid_o === 1'h1 && s_axi_bready_i && exp_b.size() > 0) begin
      xb = exp_b.pop_front();
      `CHK("bresp", s_axi_bresp_o, xb)
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'h1;
    host_u.frame({`PREFIX_EEPROM, pins, 1'h0}, ack);
    `CHK("ack", ack, 1'h0)
    rd(`OFF_LINK, {21'h0, 3'h2, pins, `PREFIX_EEPROM, pins});
    host_u.frame({`PREFIX_PROTECT, pins, 1'h0}, ack);
    `CHK("ack", ack, 1'h0)
    rd(`OFF_LINK, {21'h0, 3'h4, pins, `PREFIX_PROTECT, pins});
    for (k = 0; k < 4; k++) begin
      @(posedge clock_i);
      seed = xs(seed);
      pins <= seed[2:0];
      repeat (2) @(posedge clock_i);
      host_u.frame({`PREFIX_SENSOR, pins, 1'h0}, ack);
      `CHK("ack", ack, 1'h1)
      host_u.frame({`PREFIX_SENSOR, pins ^ 3'(2 * k + 1), 1'h0}, ack);
      `CHK("ack", ack, 1'h0)
    end
    rd(`OFF_SETUP, 34'h0);
    rd(`OFF_BUSOPT, 34'h21);
    rd(8'h1c, 34'h200000000);
    wr(8'h1c, 16'h1, 2'h2);
    pin(1'h1);
    wr(`OFF_UPPER, 16'h0200, 2'h0);
    wr(`OFF_LOWER, 16'h0100, 2'h0);
    wr(`OFF_CRIT, 16'h0400, 2'h0);
    temp(13'h0180);
    wr(`OFF_SETUP, 16'h0008, 2'h0);
    pin(1'h1);
    temp(13'h0300);
    pin(1'h0);
    rd(`OFF_TEMP, 34'h4300);
    rd(`OFF_SETUP, 34'h0018);
    wr(`OFF_SETUP, 16'h020a, 2'h0);
    pin(1'h1);
    temp(13'h01f0);
    pin(1'h1);
    temp(13'h01e8);
    pin(1'h0);
    wr(`OFF_SETUP, 16'h040a, 2'h0);
    temp(13'h00d1);
    pin(1'h0);
    temp(13'h00cf);
    pin(1'h1);
    wr(`OFF_SETUP, 16'h060a, 2'h0);
    temp(13'h0100);
    temp(13'h00a1);
    pin(1'h0);
    temp(13'h009f);
    pin(1'h1);
    wr(`OFF_SETUP, 16'h0008, 2'h0);
    temp(13'h00f0);
    pin(1'h0);
    rd(`OFF_TEMP, 34'h20f0);
    wr(`OFF_SETUP, 16'h000c, 2'h0);
    temp(13'h0300);
    pin(1'h1);
    temp(13'h0400);
    pin(1'h0);
    rd(`OFF_TEMP, 34'hc400);
    temp(13'h03ff);
    pin(1'h1);
    temp(13'h0180);
    wr(`OFF_SETUP, 16'h0009, 2'h0);
    pin(1'h1);
    temp(13'h0300);
    temp(13'h0180);
    pin(1'h0);
    wr(`OFF_SETUP, 16'h0029, 2'h0);
    pin(1'h1);
    temp(13'h0400);
    wr(`OFF_SETUP, 16'h0029, 2'h0);
    pin(1'h0);
    wr(`OFF_SETUP, 16'h00c8, 2'h0);
    wr(`OFF_UPPER, 16'h0700, 2'h0);
    wr(`OFF_CRIT, 16'h0700, 2'h0);
    rd(`OFF_UPPER, 34'h0200);
    rd(`OFF_CRIT, 34'h0400);
    wr(`OFF_SETUP, 16'h01c8, 2'h0);
    pin(1'h1);
    wr(`OFF_SETUP, 16'h00c8, 2'h0);
    temp(13'h0400);
    wr(`OFF_BUSOPT, 16'h0031, 2'h0);
    wr(`OFF_SETUP, 16'h01c8, 2'h0);
    temp(13'h0180);
    pin(1'h0);
    test_done();
  end
endmodule : test_thermal_alarm_event_logic
`default_nettype wire

// [test/thermal_alarm_sva.sv]
// Port checker of the thermal alarm block.
// Assumes binding to the top module, one clock domain and its reset.
`timescale 1ns/10ps
`default_nettype none
module thermal_alarm_sva (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        temp_valid_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n_o,
  input wire logic        alarm_o,
  input wire logic        alarm_oe_n_o,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last result or register write that may move the pin.
  logic [3:0] since;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since <= 4'hf;
    end else if (temp_valid_i || (s_axi_wvalid_i && s_axi_wready_o)) begin
      since <= 4'h0;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end
  sequence s_write_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_ack_held;
    !sda_oe_n_o [*5] ##[1:6] $rose(sda_oe_n_o);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_alarm_open_drain: assert property (alarm_o == 1'h0)
    else $error("alarm pin driven high");
  a_sda_open_drain: assert property (sda_o == 1'h0)
    else $error("data pin driven high");
  a_alarm_after_reset: assert property ($rose(resetn_i) |-> alarm_oe_n_o ##1 alarm_oe_n_o)
    else $error("alarm pin pulled after reset");
  a_alarm_has_cause: assert property ($changed(alarm_oe_n_o) |-> since <= 4'h4)
    else $error("alarm pin moved without cause");
  a_ack_one_bit: assert property ($fell(sda_oe_n_o) |-> s_ack_held)
    else $error("acknowledge not one bit long");
  a_write_answer: assert property (s_write_taken |-> ##[1:3] s_axi_bvalid_o)
    else $error("write response missing");
  a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
                                  s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_read_answer: assert property (s_read_taken |-> ##[1:2] s_axi_rvalid_o)
    else $error("read data missing");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
                                  s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
endmodule : thermal_alarm_sva
bind thermal_alarm_event_logic thermal_alarm_sva sva_u (.*);
`default_nettype wire
